// >>> hpc_params.svh
// Function
// - same-cycle host and device register write: device write kept, host data dropped.
// - write collision sets collision flag in both interrupt flag sets.
// - host access with illegal byte enables sets illegal-access flag in both sets.
// - 32-bit host access on 16-bit port is illegal and sets illegal-access flags.
// - incomplete write completed outside its correct address range sets illegal-access.
// - host read to address of pending write sets illegal-access flags.
// - host protection violation sets access-violation flag in device-to-host set.
// - address of protection violation captured in readable register.
// - write lock blocks external master writes to locked config registers.
// - lock has no effect on device writes; host writes rejected by lock, collision, illegal access or violation.
// - each event trigger source has its own disable bit.
// - interrupt source writes signature token; receiver checks it matches.
// - sent interrupts need acknowledgement within time limit, else fault.
`ifndef HPC_PARAMS_SVH
`define HPC_PARAMS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define HPC_D2H_FLG 8'h00
`define HPC_D2H_EN 8'h04
`define HPC_H2D_FLG 8'h08
`define HPC_H2D_EN 8'h0c
`define HPC_VIO_ADDR 8'h10
`define HPC_LOCK 8'h14
`define HPC_TRIG_DIS 8'h18
`define HPC_D2H_TOK 8'h1c
`define HPC_H2D_TOK 8'h20
`define HPC_D2H_SEND 8'h24
`define HPC_ACK_LIMIT 8'h28
// ----------------------------------------
// flag bit positions and ack limit reset value
// ----------------------------------------
`define HPC_B_COLL 0
`define HPC_B_ILL 1
`define HPC_B_VIO 2
`define HPC_B_ACKTO 3
`define HPC_B_TOKOK 4
`define HPC_B_LOCKREJ 5
`define HPC_ACK_LIMIT_RST 16'h00c8
`endif

// >>> hpc_pkg.sv
package hpc_pkg;
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] data;
    } hpc_hreq_s;
    typedef enum logic [1:0] {HPC_IDLE, HPC_WAITACK} hpc_ack_e;
endpackage : hpc_pkg

// >>> hpc_host_port_checker.sv
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "hpc_params.svh"
module hpc_host_port_checker
    import hpc_pkg::*;
#(
    parameter int NTRIG = 4
) (
    input wire logic clk,
    input wire logic nrst,
    // axi4-lite slave (device cpu)
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // host port, one access per cycle
    input wire hpc_hreq_s host_req,
    input wire logic host_port16,
    input wire logic host_prot_err,
    input wire logic host_ack,
    input wire logic [NTRIG-1:0] trig_in,
    output logic [31:0] host_rdata,
    output logic [NTRIG-1:0] trig_out,
    output logic d2h_irq,
    output logic h2d_irq,
    output logic safe_state
);
    // ----------------------------------------
    // axi handshake
    // ----------------------------------------
    logic aw_q, w_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic [7:0] ara_q;
    logic ar_q;
    logic dwr;
    assign dwr = aw_q && w_q && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awa_q <= 8'h00;
            wd_q <= 32'h0;
            ws_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !aw_q && !s_axi_awready) begin
                aw_q <= 1'b1;
                awa_q <= s_axi_awaddr;
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && !w_q && !s_axi_wready) begin
                w_q <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
                s_axi_wready <= 1'b1;
            end
            if (dwr) begin
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_q <= 1'b0;
                w_q <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'b00;

    // ----------------------------------------
    // host access checks
    // ----------------------------------------
    function automatic logic be_legal(input logic [3:0] be);
        be_legal = (be == 4'h1) || (be == 4'h2) || (be == 4'h4) ||
                   (be == 4'h8) || (be == 4'h3) || (be == 4'hc) ||
                   (be == 4'hf);
    endfunction : be_legal

    function automatic logic is_cfg(input logic [7:0] a);
        is_cfg = (a == `HPC_LOCK) || (a == `HPC_TRIG_DIS) ||
                 (a == `HPC_ACK_LIMIT) || (a == `HPC_D2H_EN) ||
                 (a == `HPC_H2D_EN);
    endfunction : is_cfg

    logic lock_q;
    logic pend_q;
    logic [7:0] pend_a_q;
    logic hw, hr, coll, ill, lrej, hwr_ok;
    assign hw = host_req.valid && host_req.write;
    assign hr = host_req.valid && !host_req.write;
    assign coll = hw && dwr && (host_req.addr == awa_q);
    assign lrej = hw && lock_q && is_cfg(host_req.addr);
    always_comb begin
        ill = 1'b0;
        if (host_req.valid && !be_legal(host_req.be))
            ill = 1'b1;
        if (host_req.valid && host_port16 && host_req.be == 4'hf)
            ill = 1'b1;
        if (hw && pend_q && host_req.addr != pend_a_q)
            ill = 1'b1;
        if (hr && pend_q && host_req.addr == pend_a_q)
            ill = 1'b1;
    end
    assign hwr_ok = hw && !coll && !lrej && !ill && !host_prot_err;

    // half write pending on 16-bit port
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pend_q <= 1'b0;
            pend_a_q <= 8'h00;
        end else if (hw && host_port16 && be_legal(host_req.be)) begin
            pend_q <= (host_req.be == 4'h3) && !pend_q;
            pend_a_q <= host_req.addr;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] d2h_flg_q, d2h_en_q, h2d_flg_q, h2d_en_q;
    logic [7:0] vio_addr_q;
    logic [NTRIG-1:0] trig_dis_q;
    logic [31:0] d2h_tok_q, h2d_tok_q, d2h_exp_q;
    logic [15:0] limit_q;
    logic send_q;
    logic [15:0] ack_cnt_q;
    hpc_ack_e ack_st_q;
    logic ackto, tokok;
    assign tokok = hwr_ok && host_req.addr == `HPC_H2D_TOK &&
                   host_req.data == d2h_exp_q;
    assign ackto = ack_st_q == HPC_WAITACK && ack_cnt_q >= limit_q;

    function automatic logic [7:0] evts(input logic a, input logic b,
                                        input logic c, input logic d,
                                        input logic e, input logic f);
        evts = {2'b00, f, e, d, c, b, a};
    endfunction : evts

    logic [7:0] ev_d2h, ev_h2d;
    assign ev_d2h = evts(coll, ill, host_prot_err && host_req.valid,
                         ackto, 1'b0, lrej);
    assign ev_h2d = evts(coll, ill, 1'b0, ackto, tokok, 1'b0);

    logic dw_at;
    assign dw_at = dwr;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            d2h_flg_q <= 8'h00;
            h2d_flg_q <= 8'h00;
        end else begin
            // set wins over write-one-clear
            d2h_flg_q <= (d2h_flg_q & ~((dw_at && awa_q == `HPC_D2H_FLG)
                         ? wd_q[7:0] : 8'h00)) | ev_d2h;
            h2d_flg_q <= (h2d_flg_q & ~((dw_at && awa_q == `HPC_H2D_FLG)
                         ? wd_q[7:0] : 8'h00)) | ev_h2d;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst)
            vio_addr_q <= 8'h00;
        else if (host_prot_err && host_req.valid)
            vio_addr_q <= host_req.addr;
    end

    // device write always lands; host write only when clean
    always_ff @(posedge clk) begin
        if (!nrst) begin
            d2h_en_q <= 8'h00;
            h2d_en_q <= 8'h00;
            lock_q <= 1'b0;
            trig_dis_q <= '0;
            d2h_tok_q <= 32'h0;
            h2d_tok_q <= 32'h0;
            d2h_exp_q <= 32'h0;
            limit_q <= `HPC_ACK_LIMIT_RST;
        end else if (dw_at) begin
            case (awa_q)
                `HPC_D2H_EN: d2h_en_q <= wd_q[7:0];
                `HPC_H2D_EN: h2d_en_q <= wd_q[7:0];
                `HPC_LOCK: lock_q <= lock_q | wd_q[0];
                `HPC_TRIG_DIS: trig_dis_q <= wd_q[NTRIG-1:0];
                `HPC_D2H_TOK: begin
                    d2h_tok_q <= wd_q;
                    d2h_exp_q <= wd_q;
                end
                `HPC_ACK_LIMIT: limit_q <= wd_q[15:0];
                default: ;
            endcase
        end else if (hwr_ok) begin
            case (host_req.addr)
                `HPC_D2H_EN: d2h_en_q <= host_req.data[7:0];
                `HPC_H2D_EN: h2d_en_q <= host_req.data[7:0];
                `HPC_LOCK: lock_q <= lock_q | host_req.data[0];
                `HPC_TRIG_DIS: trig_dis_q <= host_req.data[NTRIG-1:0];
                `HPC_H2D_TOK: h2d_tok_q <= host_req.data;
                `HPC_ACK_LIMIT: limit_q <= host_req.data[15:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------
    // interrupt acknowledge timeout
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ack_st_q <= HPC_IDLE;
            ack_cnt_q <= 16'h0;
            send_q <= 1'b0;
            safe_state <= 1'b0;
        end else begin
            send_q <= dw_at && awa_q == `HPC_D2H_SEND && wd_q[0];
            case (ack_st_q)
                HPC_IDLE: begin
                    ack_cnt_q <= 16'h0;
                    if (send_q)
                        ack_st_q <= HPC_WAITACK;
                end
                HPC_WAITACK: begin
                    ack_cnt_q <= ack_cnt_q + 16'h1;
                    if (host_ack) begin
                        ack_st_q <= HPC_IDLE;
                    end else if (ackto) begin
                        ack_st_q <= HPC_IDLE;
                        safe_state <= 1'b1;
                    end
                end
                default: ack_st_q <= HPC_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            d2h_irq <= 1'b0;
            h2d_irq <= 1'b0;
            trig_out <= '0;
        end else begin
            d2h_irq <= |(d2h_flg_q & d2h_en_q) ||
                       (ack_st_q == HPC_WAITACK);
            h2d_irq <= |(h2d_flg_q & h2d_en_q);
            trig_out <= trig_in & ~trig_dis_q;
        end
    end

    function automatic logic [31:0] rd(input logic [7:0] a,
                                       input logic [31:0] dtok,
                                       input logic [31:0] htok);
        case (a)
            `HPC_D2H_FLG: rd = {24'h0, d2h_flg_q};
            `HPC_D2H_EN: rd = {24'h0, d2h_en_q};
            `HPC_H2D_FLG: rd = {24'h0, h2d_flg_q};
            `HPC_H2D_EN: rd = {24'h0, h2d_en_q};
            `HPC_VIO_ADDR: rd = {24'h0, vio_addr_q};
            `HPC_LOCK: rd = {31'h0, lock_q};
            `HPC_TRIG_DIS: rd = 32'(trig_dis_q);
            `HPC_D2H_TOK: rd = dtok;
            `HPC_H2D_TOK: rd = htok;
            `HPC_ACK_LIMIT: rd = {16'h0, limit_q};
            default: rd = 32'h0;
        endcase
    endfunction : rd

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
            ar_q <= 1'b0;
            ara_q <= 8'h00;
            host_rdata <= 32'h0;
        end else begin
            s_axi_arready <= 1'b0;
            if (hr)
                host_rdata <= rd(host_req.addr, d2h_tok_q, h2d_tok_q);
            if (s_axi_arvalid && !ar_q && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                ar_q <= 1'b1;
                ara_q <= s_axi_araddr;
            end else if (ar_q && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd(ara_q, d2h_tok_q, h2d_tok_q);
                s_axi_rresp <= (ara_q > `HPC_ACK_LIMIT) ? 2'b10 : 2'b00;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                ar_q <= 1'b0;
            end
        end
    end
endmodule : hpc_host_port_checker

// >>> hpc_host_port_checker_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------
// port checks of the host port checker
// ----------------------------------------
module hpc_host_port_checker_assertions #(
    parameter int NTRIG = 4
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NTRIG-1:0] trig_in,
    input wire logic [NTRIG-1:0] trig_out,
    input wire logic d2h_irq,
    input wire logic safe_state
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence slverr_ans;
        s_axi_rvalid && s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
    endsequence
    a_trig_gated: assert property ((trig_out & ~$past(trig_in)) == 0)
        else $error("trigger out without trigger in");
    a_safe_sticky: assert property (safe_state |=> safe_state)
        else $error("safe state dropped");
    a_safe_cause: assert property ($rose(safe_state) |-> $past(d2h_irq))
        else $error("safe state without pending interrupt");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
        else $error("write response not okay");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_ar_pulse: assert property (s_axi_arready |=> !s_axi_arready)
        else $error("read address ready not a pulse");
    a_slverr_map: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr > 8'h28 |=> slverr_ans)
        else $error("unmapped read not refused");
endmodule : hpc_host_port_checker_assertions

// >>> hpc_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// external host on the master port
// ----------------------------------------
module hpc_host_model
    import hpc_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire hpc_hreq_s cmd,
    input wire logic ack_en,
    input wire logic [3:0] ack_dly,
    input wire logic d2h_irq,
    output hpc_hreq_s host_req,
    output logic host_ack
);
    logic [3:0] wait_q;
    // idle bus carries scrambled data
    assign host_req = cmd.valid ? cmd : {14'h0, ~cmd.data};
    always_ff @(posedge clk) begin
        if (!nrst || !ack_en || !d2h_irq) begin
            wait_q <= 4'h0;
            host_ack <= 1'b0;
        end else begin
            wait_q <= wait_q + 4'h1;
            host_ack <= (wait_q >= ack_dly);
        end
    end
endmodule : hpc_host_model

// >>> tb_host_port_access_checker.sv
`timescale 1ns/10ps
`include "hpc_params.svh"
module tb_host_port_access_checker
    import hpc_pkg::*;
;
    // ----------------------------------------
    // bench
    // ----------------------------------------
    localparam int NTRIG = 4;
    logic clk = 1'b0, nrst = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf, ack_dly = 4'h0, trig_in = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, host_rdata, v, t, p;
    logic s_axi_rvalid, host_ack, d2h_irq, h2d_irq, safe_state;
    logic host_port16 = 1'b0, host_prot_err = 1'b0, ack_en = 1'b0;
    logic [3:0] trig_out;
    logic [31:0] rs = 32'h00000db6;
    hpc_hreq_s cmd = '0, host_req;
    int errors = 0, check_count = 0, i;
    hpc_host_port_checker #(.NTRIG(NTRIG)) DUT (.clk, .nrst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .host_req,
        .host_port16, .host_prot_err, .host_ack, .trig_in, .host_rdata,
        .trig_out, .d2h_irq, .h2d_irq, .safe_state);
    hpc_host_model HOST (.clk, .nrst, .cmd, .ack_en, .ack_dly, .d2h_irq,
        .host_req, .host_ack);
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic summarize();
        if (errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize
    task automatic tmo(logic ok);
        if (!ok) begin
            errors++;
            summarize();
        end
    endtask : tmo
    task automatic axw(logic [7:0] a, logic [31:0] d);
        logic done;
        done = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid;
        end
        s_axi_bready <= 1'b0;
        tmo(done);
        @(posedge clk);
    endtask : axw
    task automatic axr(logic [7:0] a, output logic [31:0] d);
        logic done;
        done = 1'b0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40 && !done; n++) begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            done = s_axi_rvalid;
            d = s_axi_rdata;
        end
        s_axi_rready <= 1'b0;
        tmo(done);
        @(posedge clk);
    endtask : axr
    task automatic hst(logic w, logic [7:0] a, logic [3:0] be,
        logic [31:0] d, logic pe);
        cmd <= {1'b1, w, a, be, d};
        host_prot_err <= pe;
        @(posedge clk);
        cmd.valid <= 1'b0;
        host_prot_err <= 1'b0;
        @(posedge clk);
    endtask : hst
    // compare both flag sets, then clear them
    task automatic fl(logic [31:0] d, logic [31:0] h);
        axr(`HPC_D2H_FLG, v);
        chk("d2h_flags", d, v);
        axr(`HPC_H2D_FLG, v);
        chk("h2d_flags", h, v);
        axw(`HPC_D2H_FLG, 32'hff);
        axw(`HPC_H2D_FLG, 32'hff);
    endtask : fl
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        axr(`HPC_ACK_LIMIT, v);
        chk("ack_limit", {16'h0, `HPC_ACK_LIMIT_RST}, v);
        axr(8'h2c, v);
        chk("unmapped", 32'h0, v);
        fl(32'h0, 32'h0);
        for (i = 0; i < 16; i++) begin
            if (i != 3) begin
                hst(1'b1, `HPC_H2D_TOK, i[3:0], rnd(), 1'b0);
                chk("irq_masked", 32'h0, {30'h0, d2h_irq, h2d_irq});
                t = (i inside {1, 2, 4, 8, 12, 15}) ? 32'h0 : 32'h2;
                fl(t, t);
            end
        end
        host_port16 <= 1'b1;
        hst(1'b0, `HPC_H2D_TOK, 4'hf, 32'h0, 1'b0);
        host_port16 <= 1'b0;
        fl(32'h2, 32'h2);
        hst(1'b1, `HPC_LOCK, 4'hf, 32'h1, 1'b1);
        axr(`HPC_VIO_ADDR, v);
        chk("vio_addr", {24'h0, `HPC_LOCK}, v);
        axr(`HPC_LOCK, v);
        chk("lock_dropped", 32'h0, v);
        fl(32'h4, 32'h0);
        fork
            axw(`HPC_TRIG_DIS, 32'h5);
            begin
                @(posedge s_axi_awready);
                cmd <= {1'b1, 1'b1, `HPC_TRIG_DIS, 4'hf, 32'ha};
                @(posedge clk);
                cmd.valid <= 1'b0;
            end
        join
        axr(`HPC_TRIG_DIS, v);
        chk("collision_keep", 32'h5, v);
        fl(32'h1, 32'h1);
        t = 32'h0;
        for (i = 0; i < 20; i++) begin
            p = t;
            t = rnd();
            @(posedge clk);
            trig_in <= t[3:0];
            @(negedge clk);
            chk("trig_out", {28'h0, p[3:0] & 4'ha}, {28'h0, trig_out});
        end
        @(posedge clk);
        hst(1'b1, `HPC_LOCK, 4'hf, 32'h1, 1'b0);
        hst(1'b1, `HPC_TRIG_DIS, 4'hf, 32'hf, 1'b0);
        axr(`HPC_TRIG_DIS, v);
        chk("locked", 32'h5, v);
        fl(32'h20, 32'h0);
        axw(`HPC_TRIG_DIS, 32'h3);
        axr(`HPC_TRIG_DIS, v);
        chk("dev_write", 32'h3, v);
        t = rnd();
        axw(`HPC_D2H_TOK, t);
        hst(1'b1, `HPC_H2D_TOK, 4'hf, t, 1'b0);
        fl(32'h0, 32'h10);
        host_port16 <= 1'b1;
        hst(1'b1, `HPC_H2D_TOK, 4'h3, ~t, 1'b0);
        hst(1'b0, `HPC_H2D_TOK, 4'h3, 32'h0, 1'b0);
        chk("host_rdata", ~t, host_rdata);
        fl(32'h2, 32'h2);
        hst(1'b1, `HPC_D2H_TOK, 4'h3, ~t, 1'b0);
        host_port16 <= 1'b0;
        fl(32'h2, 32'h2);
        axw(`HPC_D2H_EN, 32'h2);
        axw(`HPC_H2D_EN, 32'h2);
        hst(1'b1, `HPC_H2D_TOK, 4'h0, t, 1'b0);
        @(posedge clk);
        chk("irq_on", 32'h3, {30'h0, d2h_irq, h2d_irq});
        fl(32'h2, 32'h2);
        axw(`HPC_ACK_LIMIT, 32'h5);
        ack_en <= 1'b1;
        axw(`HPC_D2H_SEND, 32'h1);
        for (i = 0; i < 50 && !d2h_irq; i++) @(posedge clk);
        tmo(d2h_irq);
        for (i = 0; i < 50 && d2h_irq; i++) @(posedge clk);
        chk("acked", 32'h0, {30'h0, d2h_irq, safe_state});
        ack_en <= 1'b0;
        axw(`HPC_D2H_SEND, 32'h1);
        for (i = 0; i < 50 && !safe_state; i++) @(posedge clk);
        chk("safe", 32'h1, {31'h0, safe_state});
        axr(`HPC_D2H_FLG, v);
        chk("ack_late", 32'h1, {31'h0, v[`HPC_B_ACKTO]});
        summarize();
    end
endmodule : tb_host_port_access_checker
bind hpc_host_port_checker hpc_host_port_checker_assertions #(.NTRIG(NTRIG))
    u_chk (.clk, .nrst, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trig_in, .trig_out,
    .d2h_irq, .safe_state);
